// [bsc_pkg.sv]
package bsc_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] BSC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] BSC_ADDR_INPUT = 2'h1;
  localparam logic [1:0] BSC_ADDR_DATA = 2'h2;
  localparam int BSC_ADDR_W = 2;

  // Control register field positions
  localparam int BSC_CTRL_PTR_LSB = 0;
  localparam int BSC_CTRL_VAL_BIT = 2;
  localparam int BSC_CTRL_INIT_BIT = 3;
  localparam int BSC_CTRL_SEL_BIT = 4;

  // Polynomials and presets
  localparam logic [15:0] BSC_POLY16 = 16'h1021;
  localparam logic [31:0] BSC_POLY32 = 32'h04C1_1DB7;
  localparam logic [31:0] BSC_POLY32_REFL = 32'hEDB8_8320;
  localparam logic [31:0] BSC_PRESET_ZERO = 32'h0000_0000;
  localparam logic [31:0] BSC_PRESET_ONES = 32'hFFFF_FFFF;
  localparam logic [7:0] BSC_CTRL_RESET = 8'h00;

  // Polynomial select encoding
  localparam logic BSC_SEL_32 = 1'b0;
  localparam logic BSC_SEL_16 = 1'b1;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [BSC_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } bsc_req_t;

endpackage

// [bsc_step.sv]
`timescale 1ns/10ps
`default_nettype none
module bsc_step
  import bsc_pkg::*;
(
  input wire logic [31:0] i_acc,
  input wire logic [7:0] i_byte,
  input wire logic i_sel16,
  output logic [31:0] o_acc
);

  ////////////////////////////////////////////////////////////////////////
  // One whole byte folded in a single pass of combinational logic
  always_comb begin
    logic [15:0] a16;
    logic [31:0] a32;
    a16 = i_acc[15:0] ^ {i_byte, 8'h00}; // RULE_04
    a32 = i_acc ^ {24'h00_0000, i_byte}; // RULE_07
    for (int i = 0; i < 8; i++) begin
      // Left shift, poly when old top bit set
      if (a16[15]) begin
        a16 = {a16[14:0], 1'b0} ^ BSC_POLY16; // RULE_05
      end else begin
        a16 = {a16[14:0], 1'b0};
      end
      // Right shift, reflected poly when bit out set
      if (a32[0]) begin
        a32 = {1'b0, a32[31:1]} ^ BSC_POLY32_REFL; // RULE_08
      end else begin
        a32 = {1'b0, a32[31:1]}; // RULE_06
      end
    end
    o_acc = i_sel16 ? {16'h0000, a16} : a32; // RULE_01
  end

endmodule
`default_nettype wire

// [bsc_ptr.sv]
`timescale 1ns/10ps
`default_nettype none
module bsc_ptr
  import bsc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [1:0] i_load_val,
  input wire logic i_step,
  output logic [1:0] o_ptr
);

  ////////////////////////////////////////////////////////////////////////
  // Byte pointer: load from control write, advance per data access
  logic [1:0] ptr_ff;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_ff <= 2'h0;
    end else if (i_load) begin
      ptr_ff <= i_load_val;
    end else if (i_step) begin
      ptr_ff <= ptr_ff + 2'h1; // RULE_14
    end
  end
  assign o_ptr = ptr_ff;

endmodule
`default_nettype wire

// [bsc_engine.sv]
// Operation
// RULE_01 - Offer 16-bit poly 0x1021 and 32-bit poly 0x04C11DB7; width follows.
// RULE_02 - Each byte written to the input register folds into the result.
// RULE_03 - Result lives internally; reached only via pointer and data port. The engine also mirrors it out on o_result.
// RULE_04 - 16-bit mode: XOR byte into upper eight result bits first.
// RULE_05 - 16-bit mode: eight left shifts, XOR 0x1021 when top bit was set.
// RULE_06 - 32-bit mode computes a reflected CRC.
// RULE_07 - 32-bit mode: XOR byte into lowest eight result bits first.
// RULE_08 - 32-bit mode: eight right shifts, XOR 0xEDB88320 when bit out set.
// RULE_09 - Result presets to all zeros or all ones.
// RULE_10 - Polynomial select 0 means 32-bit, 1 means 16-bit.
// RULE_11 - Initial value select 0 means zeros, 1 means ones.
// RULE_12 - Writing 1 to the init strobe loads the chosen preset.
// RULE_13 - Every input byte write yields an updated result.
// RULE_14 - Pointer picks the data port byte and advances after each access.
// RULE_15 - Result holds until init, port overwrite, or new input byte.
// RULE_16 - One byte update per clock; back-to-back writes never stall.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module bsc_engine
  import bsc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [BSC_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [31:0] o_result,
  output logic o_sel16
);

  ////////////////////////////////////////////////////////////////////////
  // Request bundle and decode
  bsc_req_t req;
  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  logic wr_ctrl;
  logic wr_input;
  logic wr_data;
  logic rd_data;
  assign wr_ctrl = req.wr && (req.addr == BSC_ADDR_CTRL);
  assign wr_input = req.wr && (req.addr == BSC_ADDR_INPUT);
  assign wr_data = req.wr && (req.addr == BSC_ADDR_DATA);
  assign rd_data = req.rd && (req.addr == BSC_ADDR_DATA);

  ////////////////////////////////////////////////////////////////////////
  // Control settings
  logic sel16_ff;
  logic val_ff;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel16_ff <= BSC_CTRL_RESET[BSC_CTRL_SEL_BIT];
      val_ff <= BSC_CTRL_RESET[BSC_CTRL_VAL_BIT];
    end else if (wr_ctrl) begin
      sel16_ff <= req.wdata[BSC_CTRL_SEL_BIT]; // RULE_10
      val_ff <= req.wdata[BSC_CTRL_VAL_BIT]; // RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result pointer
  logic [1:0] ptr;
  bsc_ptr u_ptr (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_load(wr_ctrl),
    .i_load_val(req.wdata[BSC_CTRL_PTR_LSB +: 2]),
    .i_step(wr_data || rd_data),
    .o_ptr(ptr)
  );

  // In 16-bit mode the pointer top bit is ignored
  logic [1:0] lane;
  assign lane = sel16_ff ? {1'b0, ptr[0]} : ptr;

  ////////////////////////////////////////////////////////////////////////
  // Single-cycle byte fold
  logic [31:0] result_ff;
  logic [31:0] nxt_fold;
  bsc_step u_step (
    .i_acc(result_ff),
    .i_byte(req.wdata),
    .i_sel16(sel16_ff),
    .o_acc(nxt_fold)
  );

  ////////////////////////////////////////////////////////////////////////
  // Result register: init beats input, port write touches one byte
  logic init_hit;
  logic [31:0] preset;
  assign init_hit = wr_ctrl && req.wdata[BSC_CTRL_INIT_BIT];
  assign preset = req.wdata[BSC_CTRL_VAL_BIT] ? BSC_PRESET_ONES
                                              : BSC_PRESET_ZERO; // RULE_09
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_ff <= BSC_PRESET_ZERO;
    end else if (init_hit) begin
      result_ff <= preset; // RULE_12
    end else if (wr_input) begin
      result_ff <= nxt_fold; // RULE_02 RULE_13 RULE_16
    end else if (wr_data) begin
      result_ff[lane*8 +: 8] <= req.wdata; // RULE_03
    end
  end // Otherwise held: RULE_15

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        BSC_ADDR_CTRL: o_rdata <= {3'b000, sel16_ff, 1'b0, val_ff, ptr};
        BSC_ADDR_DATA: o_rdata <= result_ff[lane*8 +: 8]; // RULE_03
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Mirrors of internal state for observation
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_result <= BSC_PRESET_ZERO;
      o_sel16 <= 1'b0;
    end else begin
      o_result <= result_ff;
      o_sel16 <= sel16_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks: control settings

  // Control write takes the polynomial select bit
  a_sel_sets: assert property ( // RULE_10
    @(posedge i_mclk) disable iff (!i_resetn)
    wr_ctrl |=> sel16_ff == $past(req.wdata[BSC_CTRL_SEL_BIT]))
    else $error("poly select not taken");

  // Control write takes the initial value select bit
  a_val_sets: assert property ( // RULE_11
    @(posedge i_mclk) disable iff (!i_resetn)
    wr_ctrl |=> val_ff == $past(req.wdata[BSC_CTRL_VAL_BIT]))
    else $error("init value select not taken");

  // Settings move only on a control write
  a_cfg_hold: assert property ( // RULE_11
    @(posedge i_mclk) disable iff (!i_resetn)
    !wr_ctrl |=> $stable(sel16_ff) && $stable(val_ff))
    else $error("settings moved without a control write");

  ////////////////////////////////////////////////////////////////////////
  // Checks: result pointer and byte lanes

  // Control write loads the pointer field
  a_ptr_load: assert property ( // RULE_14
    @(posedge i_mclk) disable iff (!i_resetn)
    wr_ctrl |=> ptr == $past(req.wdata[BSC_CTRL_PTR_LSB +: 2]))
    else $error("pointer not loaded");

  // Data port read advances the pointer
  a_ptr_step: assert property ( // RULE_14
    @(posedge i_mclk) disable iff (!i_resetn)
    (rd_data && !wr_ctrl) |=> ptr == $past(ptr) + 2'h1)
    else $error("pointer did not advance");

  // Data port write advances the pointer
  a_ptr_wstep: assert property ( // RULE_14
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_data && !wr_ctrl) |=> ptr == $past(ptr) + 2'h1)
    else $error("pointer did not advance on write");

  // Pointer holds between accesses
  a_ptr_hold: assert property ( // RULE_14
    @(posedge i_mclk) disable iff (!i_resetn)
    !(wr_ctrl || wr_data || rd_data) |=> $stable(ptr))
    else $error("pointer moved without access");

  // Half-width result keeps the upper lanes out of reach
  a_lane_narrow: assert property ( // RULE_03
    @(posedge i_mclk) disable iff (!i_resetn)
    sel16_ff |-> !lane[1])
    else $error("16-bit lane out of range");

  // Full-width result maps the pointer straight to a lane
  a_lane_wide: assert property ( // RULE_14
    @(posedge i_mclk) disable iff (!i_resetn)
    !sel16_ff |-> lane == ptr)
    else $error("32-bit lane differs from pointer");

  // Half-width pointer alternates between the two lanes
  a_lane_toggle: assert property ( // RULE_14
    @(posedge i_mclk) disable iff (!i_resetn)
    (sel16_ff && (rd_data || wr_data) && !wr_ctrl)
    |=> lane[0] != $past(lane[0]))
    else $error("16-bit lane did not alternate");

  ////////////////////////////////////////////////////////////////////////
  // Checks: result register

  // Init strobe loads the preset picked in the same write
  a_init_loads: assert property ( // RULE_12
    @(posedge i_mclk) disable iff (!i_resetn)
    init_hit |=> (result_ff == $past(preset)))
    else $error("init did not load preset");

  // All-ones preset fills the whole result
  a_preset_ones: assert property ( // RULE_09
    @(posedge i_mclk) disable iff (!i_resetn)
    (init_hit && req.wdata[BSC_CTRL_VAL_BIT]) |=> result_ff == BSC_PRESET_ONES)
    else $error("ones preset wrong");

  // All-zeros preset clears the whole result
  a_preset_zero: assert property ( // RULE_09
    @(posedge i_mclk) disable iff (!i_resetn)
    (init_hit && !req.wdata[BSC_CTRL_VAL_BIT]) |=> result_ff == BSC_PRESET_ZERO)
    else $error("zeros preset wrong");

  // Every input byte lands in the result one cycle later
  a_fold_each: assert property ( // RULE_13
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_input && !init_hit) |=> result_ff == $past(nxt_fold))
    else $error("input byte not folded");

  // Back-to-back input writes each fold without a stall
  a_fold_b2b: assert property ( // RULE_16
    @(posedge i_mclk) disable iff (!i_resetn)
    wr_input [*2] |=> result_ff == $past(nxt_fold))
    else $error("second back-to-back byte lost");

  // Half-width fold leaves the upper half clear
  a_high_zero16: assert property ( // RULE_04
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_input && sel16_ff && !init_hit) |=> result_ff[31:16] == 16'h0000)
    else $error("16-bit fold touched upper half");

  // Byte equal to the top result byte leaves a plain left shift
  a_fold16_hi: assert property ( // RULE_05
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_input && sel16_ff && req.wdata == result_ff[15:8])
    |=> result_ff[15:0] == {$past(result_ff[7:0]), 8'h00})
    else $error("16-bit matched-byte fold wrong");

  // Byte equal to the low result byte leaves a plain right shift
  a_fold32_lo: assert property ( // RULE_07
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_input && !sel16_ff && !init_hit && req.wdata == result_ff[7:0])
    |=> result_ff == {8'h00, $past(result_ff[31:8])})
    else $error("32-bit zero-byte fold wrong");

  // Result holds when nothing addresses it
  a_hold_idle: assert property ( // RULE_15
    @(posedge i_mclk) disable iff (!i_resetn)
    !(wr_ctrl || wr_input || wr_data) |=> $stable(result_ff))
    else $error("result changed without cause");

  // Control write without init leaves the result alone
  a_ctrl_keeps: assert property ( // RULE_15
    @(posedge i_mclk) disable iff (!i_resetn)
    (wr_ctrl && !init_hit) |=> $stable(result_ff))
    else $error("control write disturbed result");

  // Reading the data port leaves the result alone
  a_rd_keeps: assert property ( // RULE_15
    @(posedge i_mclk) disable iff (!i_resetn)
    rd_data |=> $stable(result_ff))
    else $error("port read disturbed result");

  // Writes to the unmapped index change nothing
  a_odd_write: assert property ( // RULE_15
    @(posedge i_mclk) disable iff (!i_resetn)
    (req.wr && !(wr_ctrl || wr_input || wr_data))
    |=> $stable(result_ff) && $stable(ptr) && $stable(sel16_ff))
    else $error("unmapped write changed state");

  // Per-lane checks of the data port
  for (genvar g = 0; g < 4; g++) begin : g_lane
    // Port write lands in the selected lane
    a_port_byte: assert property ( // RULE_03
      @(posedge i_mclk) disable iff (!i_resetn)
      (wr_data && lane == 2'(g))
      |=> result_ff[8*g +: 8] == $past(req.wdata))
      else $error("port write missed its lane");

    // Port write leaves the other lanes alone
    a_port_other: assert property ( // RULE_15
      @(posedge i_mclk) disable iff (!i_resetn)
      (wr_data && lane != 2'(g)) |=> $stable(result_ff[8*g +: 8]))
      else $error("port write touched another lane");

    // Port read returns the selected lane
    a_rdata_byte: assert property ( // RULE_03
      @(posedge i_mclk) disable iff (!i_resetn)
      (rd_data && lane == 2'(g))
      |=> o_rdata == $past(result_ff[8*g +: 8]))
      else $error("port read returned the wrong lane");
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks: read port and mirrors

  // Read data is zero outside the read slot
  a_rdata_slot: assert property ( // RULE_03
    @(posedge i_mclk) disable iff (!i_resetn)
    !req.rd |=> o_rdata == 8'h00)
    else $error("read data outside read slot");

  // Control read returns the settings and pointer
  a_rdata_ctrl: assert property ( // RULE_10
    @(posedge i_mclk) disable iff (!i_resetn)
    (req.rd && req.addr == BSC_ADDR_CTRL) |=> o_rdata ==
      {3'b000, $past(sel16_ff), 1'b0, $past(val_ff), $past(ptr)})
    else $error("control read wrong");

  // Input register reads as zero
  a_rdata_input: assert property ( // RULE_03
    @(posedge i_mclk) disable iff (!i_resetn)
    (req.rd && req.addr == BSC_ADDR_INPUT) |=> o_rdata == 8'h00)
    else $error("input read not zero");

  // Unmapped index reads as zero
  a_rdata_odd: assert property ( // RULE_03
    @(posedge i_mclk) disable iff (!i_resetn)
    (req.rd && req.addr != BSC_ADDR_CTRL && req.addr != BSC_ADDR_INPUT
      && req.addr != BSC_ADDR_DATA) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Result mirror trails the result by one cycle
  a_mirror_res: assert property ( // RULE_13
    @(posedge i_mclk) disable iff (!i_resetn)
    1'b1 |=> o_result == $past(result_ff))
    else $error("result mirror out of step");

  // Select mirror trails the setting by one cycle
  a_mirror_sel: assert property ( // RULE_10
    @(posedge i_mclk) disable iff (!i_resetn)
    1'b1 |=> o_sel16 == $past(sel16_ff))
    else $error("select mirror out of step");

endmodule
`default_nettype wire

// [bsc_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bsc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [BSC_ADDR_W-1:0] i_addr = '0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [31:0] o_result;
  logic o_sel16;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32'h8c06;
  logic [31:0] m_res = 32'h0000_0000;
  logic m_sel = 1'b0;
  logic m_val = 1'b0;
  logic [1:0] m_ptr = 2'h0;
  logic [7:0] got;

  bsc_engine uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_result(o_result), .o_sel16(o_sel16));

  //////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns period
  always #2 i_mclk = ~i_mclk;

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Reference fold of one byte into the result
  function automatic logic [31:0] fold(input logic [31:0] r,
                                       input logic [7:0] b, input logic s);
    logic [31:0] x;
    x = s ? {16'h0000, r[15:0] ^ {b, 8'h00}} : r ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      if (s) begin
        x = {16'h0000, x[14:0], 1'b0} ^ (x[15] ? 32'h0000_1021 : 32'h0);
      end else begin
        x = (x >> 1) ^ (x[0] ? 32'hEDB8_8320 : 32'h0);
      end
    end
    return x;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register port cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic ctrl(input logic [7:0] d);
    wr(BSC_ADDR_CTRL, d);
    m_ptr = d[1:0];
    m_val = d[2];
    m_sel = d[4];
    if (d[3]) m_res = m_val ? 32'hFFFF_FFFF : 32'h0000_0000;
  endtask

  // Input bytes written back to back, strobe held high
  task automatic burst(input int n, input logic [7:0] fix, input bit rnd);
    logic [7:0] d;
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= BSC_ADDR_INPUT;
    for (int i = 0; i < n; i++) begin
      d = rnd ? 8'($random(seed)) : fix;
      i_wdata <= d;
      m_res = fold(m_res, d, m_sel);
      @(posedge i_mclk);
    end
    i_wr <= 1'b0;
  endtask

  task automatic check_res(input int n);
    int idx;
    for (int i = 0; i < n; i++) begin
      idx = m_sel ? int'(m_ptr[0]) : int'(m_ptr);
      rd(BSC_ADDR_DATA, got);
      chk(got, m_res[8*idx +: 8]);
      m_ptr = m_ptr + 2'h1;
    end
  endtask

  task automatic check_ctrl();
    rd(BSC_ADDR_CTRL, got);
    chk(got, {3'b000, m_sel, 1'b0, m_val, m_ptr});
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    check_ctrl();
    check_res(4);
    check_ctrl();
    $display("test reset done");
    ctrl(8'h0c);
    burst(1, 8'h63, 0);
    check_res(4);
    chk(o_result, 32'hF946_2090);
    ctrl(8'h0d);
    burst(16, 8'h00, 1);
    check_res(4);
    ctrl(8'h08);
    burst(5, 8'h00, 1);
    check_res(4);
    burst(1, m_res[7:0], 0);
    check_res(4);
    $display("test crc32 done");
    ctrl(8'h1c);
    @(posedge i_mclk);
    #1;
    chk(o_sel16, m_sel);
    check_res(4);
    burst(1, 8'h63, 0);
    check_res(4);
    chk(o_result, 32'h0000_BD35);
    burst(8, 8'h00, 1);
    check_res(4);
    burst(1, m_res[15:8], 0);
    check_res(4);
    ctrl(8'h18);
    burst(1, 8'h63, 0);
    check_res(2);
    chk(o_result, 32'h0000_5CC5);
    $display("test crc16 done");
    ctrl(8'h02);
    wr(BSC_ADDR_DATA, 8'hA5);
    m_res[23:16] = 8'hA5;
    m_ptr = 2'h3;
    check_ctrl();
    rd(BSC_ADDR_INPUT, got);
    chk(got, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, got);
    chk(got, 8'h00);
    check_res(4);
    $display("test port done");
    summarize();
  end
endmodule
`default_nettype wire
